// file: include/ubg_consts.vh
// register map, field layout and mode codes of the ultrasonic burst generator
`ifndef UBG_CONSTS_VH
`define UBG_CONSTS_VH

// register byte offsets (the printed mode register offset is kept as its index)
`define UBG_IDX_MODE 8'hb3
`define UBG_OFF_MODE 12'h2cc
`define UBG_OFF_PWR 12'h000
`define UBG_OFF_EN 12'h004
`define UBG_OFF_STAT2 12'h008
`define UBG_OFF_PCNT_A 12'h00c
`define UBG_OFF_PCNT_B 12'h010
`define UBG_OFF_ON_A 12'h014
`define UBG_OFF_OFF_A 12'h018
`define UBG_OFF_ON_B 12'h01c
`define UBG_OFF_OFF_B 12'h020
`define UBG_OFF_GAP 12'h024

// field positions
`define UBG_BIT_REG_EN 1
`define UBG_BIT_ACT_EN 2
`define UBG_BIT_FIRE_A 0
`define UBG_BIT_FIRE_B 1
`define UBG_BIT_READY 0
`define UBG_BIT_BUSY_A 1
`define UBG_BIT_BUSY_B 2

// widths
`define UBG_W_MODE 3
`define UBG_W_PCNT 6
`define UBG_W_TIME 11
`define UBG_W_GAP 8

// drive mode codes
`define UBG_MODE_PP 3'h0
`define UBG_MODE_A_PB 3'h1
`define UBG_MODE_PA_B 3'h2
`define UBG_MODE_AB 3'h3
`define UBG_MODE_PORT 3'h4

// reset values
`define UBG_RST_MODE 3'h0
`define UBG_RST_PCNT 6'h00
`define UBG_RST_TIME 11'h000
`define UBG_RST_GAP 8'h00

`endif

// file: src/ubg_pulse_gen.v
// one burst generator channel: pulse count, on, off and leading gap timing
`timescale 1ns/1ps
`include "ubg_consts.vh"

module ubg_pulse_gen #(
    parameter CW = 6,
    parameter TW = 11,
    parameter GW = 8
) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // control
    input wire start,
    input wire stop,
    input wire [CW-1:0] pulses,
    input wire [TW-1:0] on_time,
    input wire [TW-1:0] off_time,
    input wire [GW-1:0] gap,
    // status and drive
    output reg busy_r,
    output reg gate_r,
    output reg phase_r
);

    // states
    localparam S_IDLE = 2'h0;
    localparam S_GAP = 2'h1;
    localparam S_ON = 2'h2;
    localparam S_OFF = 2'h3;

    reg [1:0] state_r; // sequencer state
    reg [TW-1:0] tmr_r; // phase timer
    reg [CW-1:0] left_r; // pulses still to emit

    // a zero time still lasts one cycle so the phase stays visible
    function [TW-1:0] ubg_len;
        input [TW-1:0] t;
        begin
            ubg_len = (t == {TW{1'b0}}) ? {TW{1'b0}} : t - 1'b1;
        end
    endfunction

    // sequencer; the gap goes before every on phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= S_IDLE;
            tmr_r <= {TW{1'b0}};
            left_r <= {CW{1'b0}};
            busy_r <= 1'b0;
            gate_r <= 1'b0;
            phase_r <= 1'b0;
        end else if (stop) begin
            // power removed: return to off at once
            state_r <= S_IDLE;
            busy_r <= 1'b0;
            gate_r <= 1'b0;
        end else begin
            case (state_r)
                S_IDLE: begin
                    // zero pulses gives an empty burst
                    if (start && pulses != {CW{1'b0}}) begin
                        left_r <= pulses;
                        phase_r <= 1'b0; // every burst opens on side a
                        busy_r <= 1'b1;
                        state_r <= S_GAP;
                        tmr_r <= {{(TW-GW){1'b0}}, gap};
                    end
                end
                S_GAP: begin
                    if (tmr_r == {TW{1'b0}}) begin
                        gate_r <= 1'b1;
                        state_r <= S_ON;
                        tmr_r <= ubg_len(on_time);
                    end else begin
                        tmr_r <= tmr_r - 1'b1;
                    end
                end
                S_ON: begin
                    if (tmr_r == {TW{1'b0}}) begin
                        gate_r <= 1'b0;
                        state_r <= S_OFF;
                        tmr_r <= ubg_len(off_time);
                    end else begin
                        tmr_r <= tmr_r - 1'b1;
                    end
                end
                S_OFF: begin
                    if (tmr_r != {TW{1'b0}}) begin
                        tmr_r <= tmr_r - 1'b1;
                    end else if (left_r == {{(CW-1){1'b0}}, 1'b1}) begin
                        busy_r <= 1'b0;
                        state_r <= S_IDLE;
                    end else begin
                        left_r <= left_r - 1'b1;
                        phase_r <= ~phase_r;
                        state_r <= S_GAP;
                        tmr_r <= {{(TW-GW){1'b0}}, gap};
                    end
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end

endmodule // ubg_pulse_gen

// file: src/ubg_burst_top.v
// apb register file and drive mode routing of the ultrasonic burst generator
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
`include "ubg_consts.vh"

// Notes on behaviour
// - drivers off until active power enabled
// - charge regulator off until software enables
// - charge ready flag in secondary status
// - three-bit mode selects five drive configurations
// - mode register at 0xB3, resets zero
// - mode 000 push-pull using A timing
// - fire bit A starts A, also B
// - pulse count per output, 0 to 63
// - 11-bit on/off times in cycles
// - 8-bit guard gap separates push-pull conduction
// - mode 001 A generator, B port pin
// - single-ended uses one switch per output
// - push-pull alternates two switches
// - port mode gates follow port pins
// - mode 011 independent generators, B own timing
// - mode 010 A port pin, B generator
// - mode 100 both outputs from port pins
module ubg_burst_top #(
    parameter CW = `UBG_W_PCNT,
    parameter TW = `UBG_W_TIME,
    parameter GW = `UBG_W_GAP
) (
    // apb slave
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // analog side
    input wire charge_ready_in,
    output reg charge_regulator_enable,
    output reg active_power_enable,
    // processor port pins
    input wire cpu_port_pin_a,
    input wire cpu_port_pin_b,
    // gate drives
    output reg gate_a,
    output reg gate_b
);

    // software registers
    reg [`UBG_W_MODE-1:0] drive_mode_select_r; // drive configuration
    reg reg_en_r; // charge regulator enable
    reg act_en_r; // active power enable
    reg fire_a_r; // fire request a
    reg fire_b_r; // fire request b
    reg [CW-1:0] pulse_count_a_r;
    reg [CW-1:0] pulse_count_b_r;
    reg [TW-1:0] on_a_r;
    reg [TW-1:0] off_a_r;
    reg [TW-1:0] on_b_r;
    reg [TW-1:0] off_b_r;
    reg [GW-1:0] guard_gap_r;

    // synchronisers for the asynchronous ready level
    reg [2:0] rdy_sync_r;
    reg rdy_r; // filtered charge ready flag
    wire rdy_nxt;

    // generator outputs, write strobe, mode decode and generator controls
    wire busy_a;
    wire busy_b;
    wire gen_a;
    wire gen_b;
    wire phase_a;
    wire wr_en;
    wire pp;
    wire start_a;
    wire start_b;
    wire stop_gen;
    wire [CW-1:0] pulses_a_eff; // pulse count handed to generator a
    // busy history: a burst has just ended when busy drops
    reg busy_a_d_r;
    reg busy_b_d_r;

    // zero-wait slave, every access completes in its access cycle
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign wr_en = psel & penable & pwrite;
    assign pp = (drive_mode_select_r == `UBG_MODE_PP);

    // register decode helper
    function hit;
        input [11:0] a;
        input [11:0] off;
        begin
            hit = (a == off);
        end
    endfunction

    // fire is a one-shot request held until the generator's burst finishes
    // the cycle after a burst holds off a restart while the fire bit clears
    assign start_a = fire_a_r & ~busy_a & ~busy_a_d_r;
    assign start_b = fire_b_r & ~busy_b & ~busy_b_d_r & ~pp;
    assign stop_gen = ~act_en_r;
    // push-pull hands both counts to generator a, wrapping at the count width
    assign pulses_a_eff = pp ? pulse_count_a_r + pulse_count_b_r : pulse_count_a_r;

    // register writes; fire bits clear when the burst finishes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive_mode_select_r <= `UBG_RST_MODE;
            reg_en_r <= 1'b0;
            act_en_r <= 1'b0;
            fire_a_r <= 1'b0;
            fire_b_r <= 1'b0;
            pulse_count_a_r <= `UBG_RST_PCNT;
            pulse_count_b_r <= `UBG_RST_PCNT;
            on_a_r <= `UBG_RST_TIME;
            off_a_r <= `UBG_RST_TIME;
            on_b_r <= `UBG_RST_TIME;
            off_b_r <= `UBG_RST_TIME;
            guard_gap_r <= `UBG_RST_GAP;
        end else begin
            // completion clear; a new write in the same cycle wins below
            // a zero count is an empty burst, so its request ends at once
            if ((busy_a_d_r && !busy_a) || stop_gen ||
                (start_a && pulses_a_eff == {CW{1'b0}})) begin
                fire_a_r <= 1'b0;
            end
            if ((busy_b_d_r && !busy_b) || stop_gen || pp ||
                (start_b && pulse_count_b_r == {CW{1'b0}})) begin
                fire_b_r <= 1'b0;
            end
            if (wr_en) begin
                if (hit(paddr, `UBG_OFF_MODE)) begin
                    drive_mode_select_r <= pwdata[`UBG_W_MODE-1:0];
                end
                if (hit(paddr, `UBG_OFF_PWR)) begin
                    reg_en_r <= pwdata[`UBG_BIT_REG_EN];
                    act_en_r <= pwdata[`UBG_BIT_ACT_EN];
                end
                // fire bits only accepted with active power on
                if (hit(paddr, `UBG_OFF_EN) && act_en_r) begin
                    if (pwdata[`UBG_BIT_FIRE_A]) begin
                        fire_a_r <= 1'b1;
                    end
                    if (pwdata[`UBG_BIT_FIRE_B] && !pp) begin
                        fire_b_r <= 1'b1;
                    end
                end
                if (hit(paddr, `UBG_OFF_PCNT_A)) begin
                    pulse_count_a_r <= pwdata[CW-1:0];
                end
                if (hit(paddr, `UBG_OFF_PCNT_B)) begin
                    pulse_count_b_r <= pwdata[CW-1:0];
                end
                if (hit(paddr, `UBG_OFF_ON_A)) begin
                    on_a_r <= pwdata[TW-1:0];
                end
                if (hit(paddr, `UBG_OFF_OFF_A)) begin
                    off_a_r <= pwdata[TW-1:0];
                end
                if (hit(paddr, `UBG_OFF_ON_B)) begin
                    on_b_r <= pwdata[TW-1:0];
                end
                if (hit(paddr, `UBG_OFF_OFF_B)) begin
                    off_b_r <= pwdata[TW-1:0];
                end
                if (hit(paddr, `UBG_OFF_GAP)) begin
                    guard_gap_r <= pwdata[GW-1:0];
                end
            end
        end
    end

    // busy edge detection for clearing fire requests
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_a_d_r <= 1'b0;
            busy_b_d_r <= 1'b0;
        end else begin
            busy_a_d_r <= busy_a;
            busy_b_d_r <= busy_b;
        end
    end

    // ready: three flops, change accepted when second and third agree
    assign rdy_nxt = (rdy_sync_r[1] == rdy_sync_r[2]) ? rdy_sync_r[2] : rdy_r;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdy_sync_r <= 3'h0;
            rdy_r <= 1'b0;
        end else begin
            rdy_sync_r <= {rdy_sync_r[1:0], charge_ready_in};
            rdy_r <= rdy_nxt;
        end
    end

    // power outputs are registered copies of the control bits, one cycle behind them
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            charge_regulator_enable <= 1'b0;
            active_power_enable <= 1'b0;
        end else begin
            charge_regulator_enable <= reg_en_r;
            active_power_enable <= act_en_r;
        end
    end

    // generator a: gap only used in push-pull
    ubg_pulse_gen #(.CW(CW), .TW(TW), .GW(GW)) u_gen_a (
        .pclk(pclk),
        .presetn(presetn),
        .start(start_a),
        .stop(stop_gen),
        .pulses(pulses_a_eff),
        .on_time(on_a_r),
        .off_time(off_a_r),
        .gap(pp ? guard_gap_r : {GW{1'b0}}),
        .busy_r(busy_a),
        .gate_r(gen_a),
        .phase_r(phase_a)
    );

    // generator b, own timing registers
    ubg_pulse_gen #(.CW(CW), .TW(TW), .GW(GW)) u_gen_b (
        .pclk(pclk),
        .presetn(presetn),
        .start(start_b),
        .stop(stop_gen),
        .pulses(pulse_count_b_r),
        .on_time(on_b_r),
        .off_time(off_b_r),
        .gap({GW{1'b0}}),
        .busy_r(busy_b),
        .gate_r(gen_b),
        .phase_r()
    );

    // gate routing per mode; reserved codes keep both switches off
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_a <= 1'b0;
            gate_b <= 1'b0;
        end else if (!act_en_r) begin
            gate_a <= 1'b0;
            gate_b <= 1'b0;
        end else begin
            case (drive_mode_select_r)
                `UBG_MODE_PP: begin
                    // one sequence, alternate pulses steered to a then b
                    gate_a <= gen_a & ~phase_a;
                    gate_b <= gen_a & phase_a;
                end
                `UBG_MODE_A_PB: begin
                    gate_a <= gen_a;
                    gate_b <= cpu_port_pin_b;
                end
                `UBG_MODE_PA_B: begin
                    gate_a <= cpu_port_pin_a;
                    gate_b <= gen_b;
                end
                `UBG_MODE_AB: begin
                    gate_a <= gen_a;
                    gate_b <= gen_b;
                end
                `UBG_MODE_PORT: begin
                    gate_a <= cpu_port_pin_a;
                    gate_b <= cpu_port_pin_b;
                end
                default: begin
                    // reserved codes: software must not use them
                    gate_a <= 1'b0;
                    gate_b <= 1'b0;
                end
            endcase
        end
    end

    // read mux, unmapped addresses read zero
    always @* begin
        prdata = 32'h0000_0000;
        if (hit(paddr, `UBG_OFF_MODE)) begin
            prdata[`UBG_W_MODE-1:0] = drive_mode_select_r;
        end else if (hit(paddr, `UBG_OFF_PWR)) begin
            prdata[`UBG_BIT_REG_EN] = reg_en_r;
            prdata[`UBG_BIT_ACT_EN] = act_en_r;
        end else if (hit(paddr, `UBG_OFF_EN)) begin
            prdata[`UBG_BIT_FIRE_A] = fire_a_r;
            prdata[`UBG_BIT_FIRE_B] = fire_b_r;
        end else if (hit(paddr, `UBG_OFF_STAT2)) begin
            prdata[`UBG_BIT_READY] = rdy_r;
            prdata[`UBG_BIT_BUSY_A] = busy_a;
            prdata[`UBG_BIT_BUSY_B] = busy_b;
        end else if (hit(paddr, `UBG_OFF_PCNT_A)) begin
            prdata[CW-1:0] = pulse_count_a_r;
        end else if (hit(paddr, `UBG_OFF_PCNT_B)) begin
            prdata[CW-1:0] = pulse_count_b_r;
        end else if (hit(paddr, `UBG_OFF_ON_A)) begin
            prdata[TW-1:0] = on_a_r;
        end else if (hit(paddr, `UBG_OFF_OFF_A)) begin
            prdata[TW-1:0] = off_a_r;
        end else if (hit(paddr, `UBG_OFF_ON_B)) begin
            prdata[TW-1:0] = on_b_r;
        end else if (hit(paddr, `UBG_OFF_OFF_B)) begin
            prdata[TW-1:0] = off_b_r;
        end else if (hit(paddr, `UBG_OFF_GAP)) begin
            prdata[GW-1:0] = guard_gap_r;
        end
    end

endmodule // ubg_burst_top

// file: sim/ubg_monitor.sv
// concurrent checks on the burst generator top ports
`timescale 1ns/1ps
`include "ubg_consts.vh"
module ubg_monitor #(
    parameter CW = 6,
    parameter TW = 11,
    parameter GW = 8
) (
    // apb slave side
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // analog side and pins
    input wire charge_ready_in,
    input wire charge_regulator_enable,
    input wire active_power_enable,
    input wire cpu_port_pin_a,
    input wire cpu_port_pin_b,
    input wire gate_a,
    input wire gate_b
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    reg [2:0] mode_r; // shadow of the drive mode, so checks know the routing
    wire pp = mode_r == `UBG_MODE_PP; // push-pull selected
    // shadow follows completed mode writes only
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r <= 3'h0;
        end else if (psel && penable && pwrite && paddr == `UBG_OFF_MODE) begin
            mode_r <= pwdata[2:0];
        end
    end
    sequence wr_s(a);
        psel && penable && pwrite && paddr == a;
    endsequence
    sequence rise_s(p);
        active_power_enable ##0 $rose(p);
    endsequence
    bus_ack_a: assert property (psel && penable |-> pready && !pslverr)
        else $error("apb access not acknowledged cleanly");
    mode_read_a: assert property (psel && !pwrite && paddr == `UBG_OFF_MODE
        |-> prdata[2:0] == mode_r) else $error("mode readback wrong");
    act_copy_a: assert property (wr_s(`UBG_OFF_PWR) |=> ##1
        active_power_enable == $past(pwdata[2], 2))
        else $error("active enable not taken");
    chg_copy_a: assert property (wr_s(`UBG_OFF_PWR) |=> ##1
        charge_regulator_enable == $past(pwdata[1], 2))
        else $error("regulator enable not taken");
    quiet_off_a: assert property (!active_power_enable && !$past(active_power_enable)
        |-> !gate_a && !gate_b) else $error("gate on without power");
    pp_split_a: assert property (pp |-> !(gate_a && gate_b))
        else $error("push-pull gates overlap");
    pp_gap_a: assert property (pp && ($rose(gate_a) || $rose(gate_b)) |-> !$past(gate_a)
        && !$past(gate_b) && !$past(gate_a, 2) && !$past(gate_b, 2))
        else $error("no gap between push-pull halves");
    port_a_a: assert property ((mode_r == 3'h4 || mode_r == 3'h2) ##0 rise_s(cpu_port_pin_a)
        |-> ##[1:3] gate_a) else $error("gate a ignores port pin");
    port_b_a: assert property ((mode_r == 3'h4 || mode_r == 3'h1) ##0 rise_s(cpu_port_pin_b)
        |-> ##[1:3] gate_b) else $error("gate b ignores port pin");
endmodule // ubg_monitor
bind ubg_burst_top ubg_monitor #(.CW(CW), .TW(TW), .GW(GW)) mon_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .charge_ready_in(charge_ready_in), .charge_regulator_enable(charge_regulator_enable),
    .active_power_enable(active_power_enable), .cpu_port_pin_a(cpu_port_pin_a),
    .cpu_port_pin_b(cpu_port_pin_b), .gate_a(gate_a), .gate_b(gate_b));

// file: sim/ubg_xfmr_model.sv
// transformer primary and charge regulator as seen from the gate drives
`timescale 1ns/1ps
module ubg_xfmr_model #(
    parameter READY_DLY = 10
) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // from the device, and the bench's counter clear
    input wire gate_a,
    input wire gate_b,
    input wire charge_regulator_enable,
    input wire clr,
    // observations
    output reg charge_ready_in,
    output reg [7:0] cnt_a,
    output reg [7:0] cnt_b,
    output reg [11:0] width_a,
    output reg clash,
    output reg alt_err
);
    reg a_q, b_q, last_b; // previous gate levels, side of the last pulse
    reg [11:0] run_a; // length of the current high phase on a
    integer chg; // charge time; the capacitor empties as soon as the regulator stops
    // count pulses, measure on time, flag shoot-through and broken alternation
    always @(posedge pclk or negedge presetn) begin
        if (!presetn || clr) begin
            {a_q, b_q, clash, alt_err, cnt_a, cnt_b} <= 20'h0;
            last_b <= 1'b1;
            run_a <= 12'h000;
            width_a <= 12'h000;
        end else begin
            a_q <= gate_a;
            b_q <= gate_b;
            run_a <= gate_a ? run_a + 12'h001 : 12'h000;
            clash <= clash | (gate_a & gate_b);
            if (a_q && !gate_a) width_a <= run_a;
            if (gate_a && !a_q) begin
                cnt_a <= cnt_a + 8'h01;
                alt_err <= alt_err | !last_b;
                last_b <= 1'b0;
            end
            if (gate_b && !b_q) begin
                cnt_b <= cnt_b + 8'h01;
                alt_err <= alt_err | last_b;
                last_b <= 1'b1;
            end
        end
    end
    // capacitor charges only while the regulator runs
    always @(posedge pclk or negedge presetn) begin
        if (!presetn || !charge_regulator_enable) begin
            chg <= 0;
        end else if (chg < READY_DLY) begin
            chg <= chg + 1;
        end
    end
    always @* charge_ready_in = (chg >= READY_DLY);
endmodule // ubg_xfmr_model

// file: sim/ultrasonic_burst_generator_tb.sv
// self-checking bench for the ultrasonic burst generator
`timescale 1ns/1ps
`include "ubg_consts.vh"
module ultrasonic_burst_generator_tb;
    reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, clr = 0;
    reg cpu_port_pin_a = 0, cpu_port_pin_b = 0;
    reg [11:0] paddr = 0;
    reg [31:0] pwdata = 0, rdat, pins;
    wire [31:0] prdata;
    wire pready, pslverr, charge_ready_in, charge_regulator_enable, active_power_enable;
    wire gate_a, gate_b, clash, alt_err;
    wire [7:0] cnt_a, cnt_b;
    wire [11:0] width_a;
    integer i, j, seed, errors = 0, tests_run = 0;
    reg [5:0] ca, cb;
    reg [10:0] on, off;
    reg [2:0] m;
    always #20 pclk = ~pclk;
    ubg_burst_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .charge_ready_in(charge_ready_in),
        .charge_regulator_enable(charge_regulator_enable),
        .active_power_enable(active_power_enable), .cpu_port_pin_a(cpu_port_pin_a),
        .cpu_port_pin_b(cpu_port_pin_b), .gate_a(gate_a), .gate_b(gate_b));
    ubg_xfmr_model mdl_u (.pclk(pclk), .presetn(presetn), .gate_a(gate_a), .gate_b(gate_b),
        .charge_regulator_enable(charge_regulator_enable), .clr(clr),
        .charge_ready_in(charge_ready_in), .cnt_a(cnt_a), .cnt_b(cnt_b), .width_a(width_a),
        .clash(clash), .alt_err(alt_err));
    // one apb transfer, request held until pready is sampled high
    task xfer(input [11:0] a, input w, input [31:0] d, output [31:0] q);
        begin
            @(posedge pclk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            while (pready !== 1'b1) @(posedge pclk);
            q = prdata;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task wr(input [11:0] a, input [31:0] d);
        xfer(a, 1'b1, d, rdat);
    endtask
    task chk(input [31:0] seen, input [31:0] exp, input [8*12:1] msg);
        begin
            tests_run = tests_run + 1;
            if (seen !== exp) begin
                errors = errors + 1;
                $display("mismatch at %0t: %0s seen %h expected %h", $time, msg, seen, exp);
            end
        end
    endtask
    task rdchk(input [11:0] a, input [31:0] exp, input [8*12:1] msg);
        begin
            xfer(a, 1'b0, 32'h0, rdat);
            chk(rdat, exp, msg);
        end
    endtask
    // poll busy bits; a burst that never ends counts as a mismatch
    task fire_wait(input [31:0] bits);
        begin
            clr <= 1'b1;
            @(posedge pclk);
            clr <= 1'b0;
            wr(`UBG_OFF_EN, bits);
            rdat = 32'h0000_0006; // force at least one status poll
            for (j = 0; j < 300 && rdat[2:1] !== 2'b00; j = j + 1)
                xfer(`UBG_OFF_STAT2, 1'b0, 32'h0, rdat);
            chk(j < 300, 1, "burst hang");
        end
    endtask
    // push-pull shares count_a+count_b (6-bit wrap) starting on a
    function [31:0] pp_share(input [5:0] a, input [5:0] b, input side);
        reg [6:0] t;
        begin
            t = {1'b0, a + b};
            pp_share = side ? t / 2 : (t + 7'h01) / 2;
        end
    endfunction
    function [31:0] port_exp(input [2:0] md, input pa, input pb);
        port_exp = {(md == 3'h2 || md == 3'h4) & pa, (md == 3'h1 || md == 3'h4) & pb};
    endfunction
    task finish_test;
        begin
            $display("comparisons %0d mismatches %0d", tests_run, errors);
            if (errors == 0 && tests_run > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask
    // watchdog sized well above the longest burst sequence
    initial begin
        repeat (20000) @(posedge pclk);
        errors = errors + 1;
        finish_test;
    end
    initial begin
        seed = 57;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        chk({gate_a, gate_b, active_power_enable}, 0, "quiet start");
        chk(charge_regulator_enable, 0, "reg off");
        rdchk(`UBG_OFF_MODE, 0, "mode reset");
        rdchk(12'hffc, 0, "unmapped");
        fire_wait(32'h1);
        chk(cnt_a, 0, "fire unpowered");
        $display("quiet start test done");
        wr(`UBG_OFF_PWR, 32'h2);
        @(posedge pclk);
        @(negedge pclk);
        chk(charge_regulator_enable, 1, "reg on");
        repeat (16) @(posedge pclk);
        rdchk(`UBG_OFF_STAT2, 1, "charge ready");
        wr(`UBG_OFF_PWR, 32'h6);
        $display("power test done");
        wr(`UBG_OFF_MODE, `UBG_MODE_AB);
        for (i = 0; i < 3; i = i + 1) begin
            ca = (i == 0) ? 6'h0 : {$random(seed)} % 6;
            cb = {$random(seed)} % 6;
            on = {$random(seed)} % 5;
            off = 1 + {$random(seed)} % 4;
            wr(`UBG_OFF_PCNT_A, ca);
            wr(`UBG_OFF_PCNT_B, cb);
            wr(`UBG_OFF_ON_A, on);
            wr(`UBG_OFF_OFF_A, off);
            wr(`UBG_OFF_ON_B, on + 11'h1);
            wr(`UBG_OFF_OFF_B, off);
            fire_wait(32'h3);
            chk(cnt_a, ca, "count a");
            chk(cnt_b, cb, "count b");
            if (ca != 0) chk(width_a, (on == 0) ? 1 : on, "on time a");
            rdchk(`UBG_OFF_EN, 0, "fire clear");
        end
        $display("independent test done");
        wr(`UBG_OFF_MODE, `UBG_MODE_PP);
        for (i = 0; i < 3; i = i + 1) begin
            ca = (i == 0) ? 6'h3f : 1 + {$random(seed)} % 5;
            cb = 1 + {$random(seed)} % 5;
            wr(`UBG_OFF_PCNT_A, ca);
            wr(`UBG_OFF_PCNT_B, cb);
            wr(`UBG_OFF_GAP, {$random(seed)} % 4);
            fire_wait(32'h1);
            chk(cnt_a, pp_share(ca, cb, 1'b0), "pp count a");
            chk(cnt_b, pp_share(ca, cb, 1'b1), "pp count b");
            chk({clash, alt_err}, 0, "pp alternate");
        end
        $display("push-pull test done");
        for (i = 0; i < 3; i = i + 1) begin
            m = (i == 2) ? `UBG_MODE_PORT : i + 1;
            wr(`UBG_OFF_MODE, m);
            for (j = 0; j < 4; j = j + 1) begin
                pins = $random(seed);
                cpu_port_pin_a <= pins[0];
                cpu_port_pin_b <= pins[1];
                repeat (4) @(posedge pclk);
                @(negedge pclk);
                chk({gate_a, gate_b}, port_exp(m, pins[0], pins[1]), "port route");
                @(posedge pclk);
            end
        end
        wr(`UBG_OFF_PWR, 32'h0);
        repeat (3) @(posedge pclk);
        @(negedge pclk);
        chk({gate_a, gate_b, active_power_enable}, 0, "power off");
        $display("port drive test done");
        finish_test;
    end
endmodule // ultrasonic_burst_generator_tb
